// ---- core/pwf_pkg.sv ----
// How it works
// - frame destination address must be unicast
// - every tunnel packet carries an Ethernet header
// - VLAN tag handled; node inserts and strips it
// - core maps VLAN priority from DSCP
// - no fragmentation; no-fragment flag always set
// - core holds configurable 6-bit DSCP values
// - IPv4 and IPv6 headers built and accepted
// - node holds four distinct core endpoint addresses
// - no session before endpoint security is ready
// - one local endpoint address for all sessions
// - core marks control with policy, signals non-zero
// - node control DSCP from attribute, else zero
// - core marks data and latency requests per flow
// - node latency responses use signalled value or request's; core uses control DSCP
// - node probe responses use return value or request's; core uses control DSCP
// - core sends upstream flow attribute with DSCP
// - node marks upstream data per flow attribute
// - node works without UDP; capability is advertised
// - core uses UDP when configured and capable
// - node adopts UDP from first initial request
package pwf_pkg;

    localparam int EP_SLOTS = 4;
    localparam int FLOW_SLOTS = 4;
    localparam int MAC_GROUP_BIT = 40;
    localparam logic [5:0] DSCP_BEST_EFFORT = 6'h00;
    localparam logic [12:0] FRAG_OFF_NONE = 13'h0000;
    localparam logic [11:0] VLAN_NONE = 12'h000;

    typedef enum logic [2:0] {
        PK_CTRL, PK_DATA, PK_LAT_REQ, PK_LAT_RSP, PK_BFD_REQ, PK_BFD_RSP
    } pwf_kind_t;

    typedef enum logic [2:0] {
        AT_NONE, AT_INIT_REQ, AT_CC_DSCP, AT_LAT_DSCP, AT_BFD_DSCP, AT_UP_FLOW
    } pwf_attr_t;

    // one outer header, carried as fields rather than serialised bytes
    typedef struct packed {
        logic [47:0] ethDst;
        logic [47:0] ethSrc;
        logic vlanOn;
        logic [2:0] vlanPcp;
        logic [11:0] vlanId;
        logic ipV6;
        logic [5:0] dscp;
        logic noFragFlag;
        logic moreFrag;
        logic [12:0] fragOff;
        logic [127:0] srcIp;
        logic [127:0] dstIp;
        logic udpOn;
        pwf_kind_t kind;
        logic [7:0] flowId;
        pwf_attr_t attr;
        logic [5:0] attrDscp;
        logic [7:0] attrFlow;
    } pwf_hdr_t;

    localparam pwf_hdr_t HDR_IDLE = '0;

    function automatic logic [2:0] pcp_of(input logic [5:0] dscp);
        return dscp[5:3];
    endfunction

    // tag is removed before the header reaches the user side
    function automatic pwf_hdr_t strip_vlan(input pwf_hdr_t h);
        pwf_hdr_t r;
        r = h;
        r.vlanOn = 1'b0;
        r.vlanPcp = 3'h0;
        r.vlanId = VLAN_NONE;
        return r;
    endfunction

endpackage

// ---- core/pwf_link_if.sv ----
`timescale 1ns/1ps
interface pwf_link_if;
    import pwf_pkg::*;
    logic downValid;
    logic downReady;
    pwf_hdr_t downHdr;
    logic upValid;
    logic upReady;
    pwf_hdr_t upHdr;

    modport node (
        input downValid, downHdr, upReady,
        output downReady, upValid, upHdr
    );
    modport core (
        output downValid, downHdr, upReady,
        input downReady, upValid, upHdr
    );
endinterface

// ---- core/pwf_hdr_check.sv ----
`timescale 1ns/1ps
module pwf_hdr_check import pwf_pkg::*; (
    input pwf_hdr_t hdr, // header under test
    input wire logic [47:0] ownMac, // our station address
    input wire logic [127:0] ownIp, // our endpoint address
    output logic ok, // header accepted
    output logic badMac, // group or foreign destination
    output logic badFrag // fragment or missing flag
);
    logic ipMatch;

    always_comb begin
        badMac = hdr.ethDst[MAC_GROUP_BIT] || (hdr.ethDst != ownMac);
        badFrag = !hdr.noFragFlag || hdr.moreFrag || (hdr.fragOff != FRAG_OFF_NONE);
        // v4 addresses sit in the low word, upper bits ignored
        ipMatch = hdr.ipV6 ? (hdr.dstIp == ownIp) : (hdr.dstIp[31:0] == ownIp[31:0]);
        ok = !badMac && !badFrag && ipMatch;
    end
endmodule

// ---- core/pwf_node_end.sv ----
`timescale 1ns/1ps
module pwf_node_end import pwf_pkg::*; (
    input wire logic sys_clk, // clock
    input wire logic nrst, // async reset, active low
    pwf_link_if.node link, // link to the core
    input wire logic [47:0] ownMac, // node station address
    input wire logic [127:0] ownIp, // node endpoint address
    input wire logic useV6, // build IPv6 outer headers
    input wire logic vlanInsert, // insert a VLAN tag upstream
    input wire logic [11:0] vlanId, // tag identifier
    input wire logic udpCapable, // node offers UDP framing
    input wire logic ikeMutual, // mutual authentication exists
    input wire logic [EP_SLOTS-1:0] saReady, // security ready per endpoint
    input wire logic txValid, // upstream request
    output logic txReady, // request can be taken
    input pwf_kind_t txKind, // packet class
    input wire logic [7:0] txFlow, // flow identifier
    input wire logic [1:0] txEp, // endpoint slot to send to
    input wire logic [5:0] txReqDscp, // DSCP of the request answered
    input wire logic [47:0] txDstMac, // next hop address
    output logic txRefused, // request dropped, one cycle
    output logic rxValid, // received header, one cycle
    output pwf_hdr_t rxHdr, // received header, tag stripped
    output logic [1:0] rxEp, // endpoint slot of the sender
    output logic rxDrop, // received header rejected, one cycle
    output logic udpMode, // UDP framing in use
    output logic udpAdvert, // capability for the config channel
    output logic [EP_SLOTS-1:0] epUsed // endpoint slots in use
);
    typedef struct packed {
        logic [EP_SLOTS-1:0][127:0] epAddr;
        logic [EP_SLOTS-1:0] epUsed;
        logic [5:0] ccDscp;
        logic latSet;
        logic [5:0] latDscp;
        logic bfdSet;
        logic [5:0] bfdDscp;
        logic [FLOW_SLOTS-1:0] upSet;
        logic [FLOW_SLOTS-1:0][5:0] upDscp;
        logic udpMode;
        logic initSeen;
        logic upValid;
        pwf_hdr_t upHdr;
        logic rxValid;
        pwf_hdr_t rxHdr;
        logic [1:0] rxEp;
        logic rxDrop;
        logic txRefused;
    } pwf_node_st_t;

    pwf_node_st_t st_ff;
    pwf_node_st_t nxt_st;
    logic chkOk;

    pwf_hdr_check u_check (
        .hdr(link.downHdr),
        .ownMac(ownMac),
        .ownIp(ownIp),
        .ok(chkOk),
        .badMac(),
        .badFrag()
    );

    // returns {hit, slot}
    function automatic logic [2:0] ep_find(
        input logic [EP_SLOTS-1:0][127:0] addr,
        input logic [EP_SLOTS-1:0] used,
        input logic [127:0] ip
    );
        logic [2:0] r;
        r = 3'h0;
        for (int i = EP_SLOTS - 1; i >= 0; i--) begin
            if (used[i] && addr[i] == ip) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction

    // returns {found, slot} of the lowest free slot
    function automatic logic [2:0] ep_free(input logic [EP_SLOTS-1:0] used);
        logic [2:0] r;
        r = 3'h0;
        for (int i = EP_SLOTS - 1; i >= 0; i--) begin
            if (!used[i]) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [5:0] pick_dscp(
        input pwf_node_st_t s,
        input pwf_kind_t kind,
        input logic [7:0] flow,
        input logic [5:0] reqDscp
    );
        logic [5:0] d;
        d = DSCP_BEST_EFFORT;
        unique case (kind)
            PK_CTRL: d = s.ccDscp;
            PK_LAT_RSP: d = s.latSet ? s.latDscp : reqDscp;
            PK_BFD_RSP: d = s.bfdSet ? s.bfdDscp : reqDscp;
            PK_DATA: begin
                // without a flow attribute the data goes best effort
                if (s.upSet[flow[1:0]]) begin
                    d = s.upDscp[flow[1:0]];
                end
            end
            PK_LAT_REQ, PK_BFD_REQ: d = reqDscp;
        endcase
        return d;
    endfunction

    // the upstream register is free, or drains this cycle
    assign txReady = !st_ff.upValid || link.upReady;
    // headers are consumed in one cycle; no stall toward the core
    assign link.downReady = 1'b1;

    always_comb begin
        pwf_hdr_t h;
        pwf_hdr_t d;
        logic [2:0] hit;
        logic [2:0] free;
        logic [1:0] slot;
        logic known;
        h = HDR_IDLE;
        d = link.downHdr;
        hit = 3'h0;
        free = 3'h0;
        slot = 2'h0;
        known = 1'b0;
        nxt_st = st_ff;
        nxt_st.rxValid = 1'b0;
        nxt_st.rxDrop = 1'b0;
        nxt_st.txRefused = 1'b0;
        if (st_ff.upValid && link.upReady) begin
            nxt_st.upValid = 1'b0;
        end

        if (txValid && txReady) begin
            if (txDstMac[MAC_GROUP_BIT] || !st_ff.epUsed[txEp]) begin
                nxt_st.txRefused = 1'b1;
            end else if (ikeMutual && !saReady[txEp]) begin
                nxt_st.txRefused = 1'b1;
            end else begin
                h.ethDst = txDstMac;
                h.ethSrc = ownMac;
                h.vlanOn = vlanInsert;
                h.vlanId = vlanInsert ? vlanId : VLAN_NONE;
                h.ipV6 = useV6;
                h.dscp = pick_dscp(st_ff, txKind, txFlow, txReqDscp);
                h.vlanPcp = vlanInsert ? pcp_of(h.dscp) : 3'h0;
                h.noFragFlag = 1'b1;
                h.moreFrag = 1'b0;
                h.fragOff = FRAG_OFF_NONE;
                h.srcIp = ownIp;
                h.dstIp = st_ff.epAddr[txEp];
                h.udpOn = st_ff.udpMode;
                h.kind = txKind;
                h.flowId = txFlow;
                h.attr = AT_NONE;
                nxt_st.upValid = 1'b1;
                nxt_st.upHdr = h;
            end
        end

        if (link.downValid) begin
            hit = ep_find(st_ff.epAddr, st_ff.epUsed, d.srcIp);
            free = ep_free(st_ff.epUsed);
            known = hit[2];
            slot = hit[1:0];
            // control traffic from a new address takes a free slot
            if (!known && free[2] && d.kind == PK_CTRL) begin
                known = 1'b1;
                slot = free[1:0];
            end
            if (!chkOk || !known) begin
                nxt_st.rxDrop = 1'b1;
            end else begin
                nxt_st.epAddr[slot] = d.srcIp;
                nxt_st.epUsed[slot] = 1'b1;
                nxt_st.rxValid = 1'b1;
                nxt_st.rxHdr = strip_vlan(d);
                nxt_st.rxEp = slot;
                if (d.kind == PK_CTRL) begin
                    unique case (d.attr)
                        AT_INIT_REQ: begin
                            // only the first initial request decides framing
                            if (!st_ff.initSeen) begin
                                nxt_st.initSeen = 1'b1;
                                nxt_st.udpMode = udpCapable && d.udpOn;
                            end
                        end
                        AT_CC_DSCP: nxt_st.ccDscp = d.attrDscp;
                        AT_LAT_DSCP: begin
                            nxt_st.latSet = 1'b1;
                            nxt_st.latDscp = d.attrDscp;
                        end
                        AT_BFD_DSCP: begin
                            nxt_st.bfdSet = 1'b1;
                            nxt_st.bfdDscp = d.attrDscp;
                        end
                        AT_UP_FLOW: begin
                            nxt_st.upSet[d.attrFlow[1:0]] = 1'b1;
                            nxt_st.upDscp[d.attrFlow[1:0]] = d.attrDscp;
                        end
                        AT_NONE: begin
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
            st_ff.ccDscp <= DSCP_BEST_EFFORT;
            st_ff.upHdr <= HDR_IDLE;
            st_ff.rxHdr <= HDR_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.upValid = st_ff.upValid;
    assign link.upHdr = st_ff.upHdr;
    assign txRefused = st_ff.txRefused;
    assign rxValid = st_ff.rxValid;
    assign rxHdr = st_ff.rxHdr;
    assign rxEp = st_ff.rxEp;
    assign rxDrop = st_ff.rxDrop;
    assign udpMode = st_ff.udpMode;
    assign udpAdvert = udpCapable;
    assign epUsed = st_ff.epUsed;
endmodule

// ---- core/pwf_core_end.sv ----
`timescale 1ns/1ps
module pwf_core_end import pwf_pkg::*; (
    input wire logic sys_clk, // clock
    input wire logic nrst, // async reset, active low
    pwf_link_if.core link, // link to the node
    input wire logic [47:0] ownMac, // core station address
    input wire logic [127:0] ownIp, // core endpoint address
    input wire logic useV6, // build IPv6 outer headers
    input wire logic vlanOn, // insert a VLAN tag
    input wire logic [11:0] vlanId, // tag identifier
    input wire logic udpCfg, // UDP framing configured
    input wire logic nodeUdpCap, // all terminating nodes capable
    input wire logic [5:0] ctrlDscp, // policy DSCP for control
    input wire logic [FLOW_SLOTS-1:0][5:0] flowDscp, // policy DSCP per flow
    input wire logic [5:0] bfdDscp, // policy DSCP for probes
    input wire logic [5:0] upFlowDscp, // upstream flow policy DSCP
    input wire logic [5:0] latRspDscp, // value for latency responses
    input wire logic [5:0] bfdRetDscp, // value for probe responses
    input wire logic txValid, // downstream request
    output logic txReady, // request can be taken
    input pwf_kind_t txKind, // packet class
    input wire logic [7:0] txFlow, // flow identifier
    input pwf_attr_t txAttr, // attribute on control packets
    input wire logic [7:0] txAttrFlow, // flow named by the attribute
    input wire logic [47:0] txDstMac, // node or next hop address
    input wire logic [127:0] txDstIp, // node endpoint address
    output logic txRefused, // request dropped, one cycle
    output logic rxValid, // received header, one cycle
    output pwf_hdr_t rxHdr, // received header, tag stripped
    output logic rxDrop // received header rejected, one cycle
);
    typedef struct packed {
        logic downValid;
        pwf_hdr_t downHdr;
        logic rxValid;
        pwf_hdr_t rxHdr;
        logic rxDrop;
        logic txRefused;
    } pwf_core_st_t;

    pwf_core_st_t st_ff;
    pwf_core_st_t nxt_st;
    logic chkOk;

    pwf_hdr_check u_check (
        .hdr(link.upHdr),
        .ownMac(ownMac),
        .ownIp(ownIp),
        .ok(chkOk),
        .badMac(),
        .badFrag()
    );

    assign txReady = !st_ff.downValid || link.downReady;
    assign link.upReady = 1'b1;

    always_comb begin
        pwf_hdr_t h;
        h = HDR_IDLE;
        nxt_st = st_ff;
        nxt_st.rxValid = 1'b0;
        nxt_st.rxDrop = 1'b0;
        nxt_st.txRefused = 1'b0;
        if (st_ff.downValid && link.downReady) begin
            nxt_st.downValid = 1'b0;
        end
        if (txValid && txReady) begin
            if (txDstMac[MAC_GROUP_BIT]) begin
                nxt_st.txRefused = 1'b1;
            end else begin
                h.ethDst = txDstMac;
                h.ethSrc = ownMac;
                h.ipV6 = useV6;
                unique case (txKind)
                    PK_CTRL: h.dscp = ctrlDscp;
                    PK_DATA, PK_LAT_REQ: h.dscp = flowDscp[txFlow[1:0]];
                    PK_BFD_REQ: h.dscp = bfdDscp;
                    PK_LAT_RSP, PK_BFD_RSP: h.dscp = ctrlDscp;
                endcase
                h.vlanOn = vlanOn;
                h.vlanId = vlanOn ? vlanId : VLAN_NONE;
                h.vlanPcp = vlanOn ? pcp_of(h.dscp) : 3'h0;
                h.noFragFlag = 1'b1;
                h.fragOff = FRAG_OFF_NONE;
                h.srcIp = ownIp;
                h.dstIp = txDstIp;
                h.udpOn = udpCfg && nodeUdpCap;
                h.kind = txKind;
                h.flowId = txFlow;
                h.attr = (txKind == PK_CTRL) ? txAttr : AT_NONE;
                h.attrFlow = txAttrFlow;
                unique case (h.attr)
                    AT_CC_DSCP: h.attrDscp = ctrlDscp;
                    AT_LAT_DSCP: h.attrDscp = latRspDscp;
                    AT_BFD_DSCP: h.attrDscp = bfdRetDscp;
                    AT_UP_FLOW: h.attrDscp = upFlowDscp;
                    AT_NONE, AT_INIT_REQ: h.attrDscp = DSCP_BEST_EFFORT;
                    default: h.attrDscp = DSCP_BEST_EFFORT;
                endcase
                nxt_st.downValid = 1'b1;
                nxt_st.downHdr = h;
            end
        end
        if (link.upValid) begin
            if (chkOk) begin
                nxt_st.rxValid = 1'b1;
                nxt_st.rxHdr = strip_vlan(link.upHdr);
            end else begin
                nxt_st.rxDrop = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.downValid = st_ff.downValid;
    assign link.downHdr = st_ff.downHdr;
    assign txRefused = st_ff.txRefused;
    assign rxValid = st_ff.rxValid;
    assign rxHdr = st_ff.rxHdr;
    assign rxDrop = st_ff.rxDrop;
endmodule

// ---- tb/pwf_link_sva.sv ----
`timescale 1ns/1ps
module pwf_link_sva import pwf_pkg::*; (
    input wire logic sys_clk, // clock
    input wire logic nrst, // async reset, active low
    input wire logic downValid, // core header valid
    input wire logic downReady, // node ready
    input pwf_hdr_t downHdr, // header to node
    input wire logic upValid, // node header valid
    input wire logic upReady, // core ready
    input pwf_hdr_t upHdr // header to core
);
    logic seenUp_ff;
    logic [127:0] firstSrc_ff;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // later upstream packets are held to the first source address seen
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            seenUp_ff <= 1'b0;
            firstSrc_ff <= '0;
        end else if (upValid && !seenUp_ff) begin
            seenUp_ff <= 1'b1;
            firstSrc_ff <= upHdr.srcIp;
        end
    end
    a_down_unicast: assert property (downValid |-> !downHdr.ethDst[MAC_GROUP_BIT])
        else $error("group address sent downstream");
    a_up_unicast: assert property (upValid |-> !upHdr.ethDst[MAC_GROUP_BIT])
        else $error("group address sent upstream");
    a_down_no_frag: assert property (downValid |-> downHdr.noFragFlag && !downHdr.moreFrag
        && downHdr.fragOff == FRAG_OFF_NONE) else $error("downstream header may fragment");
    a_up_no_frag: assert property (upValid |-> upHdr.noFragFlag && !upHdr.moreFrag
        && upHdr.fragOff == FRAG_OFF_NONE) else $error("upstream header may fragment");
    a_down_pcp_map: assert property (downValid && downHdr.vlanOn |->
        downHdr.vlanPcp == downHdr.dscp[5:3]) else $error("downstream priority not from dscp");
    a_up_pcp_map: assert property (upValid && upHdr.vlanOn |->
        upHdr.vlanPcp == upHdr.dscp[5:3]) else $error("upstream priority not from dscp");
    a_up_one_src: assert property (upValid && seenUp_ff |-> upHdr.srcIp == firstSrc_ff)
        else $error("upstream source address changed");
    a_down_attr_ctrl: assert property (downValid && downHdr.kind != PK_CTRL |->
        downHdr.attr == AT_NONE) else $error("attribute on a non-control packet");
    c_down_ctrl: cover property (downValid && downReady && downHdr.kind == PK_CTRL);
    c_up_lat: cover property (upValid && upReady && upHdr.kind == PK_LAT_RSP);
    c_up_v6: cover property (upValid && upHdr.vlanOn && upHdr.ipV6);
endmodule

// ---- tb/tb_pseudowire_outer_header_framer.sv ----
`timescale 1ns/1ps
module tb_pseudowire_outer_header_framer import pwf_pkg::*; ;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    int mismatches = 0;
    int testsRun = 0;
    int i;
    logic [47:0] nMac = 48'h02AA_0000_0001;
    logic [127:0] nIp = 128'h2001_0DB8_0000_0000_0000_0000_0A00_0001;
    logic [127:0] cIp = 128'h2001_0DB8_0000_0000_0000_0000_0B00_0001;
    logic v6 = 1'b0, udpCap = 1'b1, ike = 1'b0, udpCfg = 1'b1, nodeCap = 1'b1, vlan = 1'b1;
    logic [3:0] saRdy = 4'hF;
    logic [5:0] ctrlD = 6'h2E, bfdD = 6'h30, upFlowD = 6'h0A, latD = 6'h1A, bfdRetD = 6'h22;
    logic [3:0][5:0] flowD = {6'h20, 6'h08, 6'h18, 6'h04};
    logic nTxValid = 1'b0, cTxValid = 1'b0;
    pwf_kind_t nTxKind = PK_CTRL, cTxKind = PK_CTRL;
    pwf_attr_t cTxAttr = AT_NONE;
    logic [7:0] nTxFlow = 8'h00, cTxFlow = 8'h00, cTxAttrFlow = 8'h00;
    logic [1:0] nTxEp = 2'h0;
    logic [5:0] nTxReq = 6'h00;
    logic [47:0] nTxMac = 48'h0, cTxMac = 48'h0;
    logic nTxReady, nTxRef, nRxValid, nRxDrop, nUdpMode, nUdpAdvert;
    logic cTxReady, cTxRef, cRxValid, cRxDrop, sentV, refd, gotV, gotDrop;
    logic [1:0] nRxEp;
    logic [3:0] nEpUsed;
    pwf_hdr_t nRxHdr, cRxHdr, hdr;
    pwf_kind_t upK [4] = '{PK_CTRL, PK_LAT_RSP, PK_BFD_RSP, PK_DATA};
    pwf_attr_t atK [4] = '{AT_CC_DSCP, AT_LAT_DSCP, AT_BFD_DSCP, AT_UP_FLOW};
    pwf_kind_t dnK [3] = '{PK_DATA, PK_LAT_REQ, PK_BFD_REQ};
    logic [5:0] aft [4];
    logic [5:0] dnE [3];

    pwf_link_if lnk ();
    pwf_node_end u_pwf_node_end (.sys_clk(sys_clk), .nrst(nrst), .link(lnk), .ownMac(nMac),
        .ownIp(nIp), .useV6(v6), .vlanInsert(vlan), .vlanId(12'h00A), .udpCapable(udpCap),
        .ikeMutual(ike), .saReady(saRdy), .txValid(nTxValid), .txReady(nTxReady),
        .txKind(nTxKind), .txFlow(nTxFlow), .txEp(nTxEp), .txReqDscp(nTxReq),
        .txDstMac(nTxMac), .txRefused(nTxRef), .rxValid(nRxValid), .rxHdr(nRxHdr),
        .rxEp(nRxEp), .rxDrop(nRxDrop), .udpMode(nUdpMode), .udpAdvert(nUdpAdvert),
        .epUsed(nEpUsed));
    pwf_core_end u_pwf_core_end (.sys_clk(sys_clk), .nrst(nrst), .link(lnk),
        .ownMac(48'h02CC_0000_0001), .ownIp(cIp), .useV6(v6), .vlanOn(vlan),
        .vlanId(12'h00A), .udpCfg(udpCfg), .nodeUdpCap(nodeCap), .ctrlDscp(ctrlD),
        .flowDscp(flowD), .bfdDscp(bfdD), .upFlowDscp(upFlowD), .latRspDscp(latD),
        .bfdRetDscp(bfdRetD), .txValid(cTxValid), .txReady(cTxReady), .txKind(cTxKind),
        .txFlow(cTxFlow), .txAttr(cTxAttr), .txAttrFlow(cTxAttrFlow), .txDstMac(cTxMac),
        .txDstIp(nIp), .txRefused(cTxRef), .rxValid(cRxValid), .rxHdr(cRxHdr),
        .rxDrop(cRxDrop));
    pwf_link_sva u_pwf_link_sva (.sys_clk(sys_clk), .nrst(nrst), .downValid(lnk.downValid),
        .downReady(lnk.downReady), .downHdr(lnk.downHdr), .upValid(lnk.upValid),
        .upReady(lnk.upReady), .upHdr(lnk.upHdr));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic complete_run(input bit hung);
        if (hung) mismatches++;
        $display("comparisons %0d, mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        testsRun++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // one request from either end; captures the wire and the far end's verdict
    task automatic send(input bit dn, input pwf_kind_t k, input pwf_attr_t a,
            input logic [7:0] f, input logic [5:0] rq, input logic [47:0] mac);
        int n;
        @(posedge sys_clk);
        #1;
        cTxKind = k;
        nTxKind = k;
        cTxAttr = a;
        cTxFlow = f;
        cTxAttrFlow = f;
        nTxFlow = f;
        nTxReq = rq;
        cTxMac = mac;
        nTxMac = mac;
        cTxValid = dn;
        nTxValid = !dn;
        for (n = 0; !(dn ? cTxReady : nTxReady); n++) begin
            if (n == 20) complete_run(1'b1);
            @(posedge sys_clk);
            #1;
        end
        @(posedge sys_clk);
        #1;
        cTxValid = 1'b0;
        nTxValid = 1'b0;
        hdr = dn ? lnk.downHdr : lnk.upHdr;
        sentV = dn ? lnk.downValid : lnk.upValid;
        refd = dn ? cTxRef : nTxRef;
        @(posedge sys_clk);
        #1;
        gotV = dn ? nRxValid : cRxValid;
        gotDrop = dn ? nRxDrop : cRxDrop;
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        aft = '{ctrlD, latD, bfdRetD, upFlowD};
        dnE = '{flowD[1], flowD[1], bfdD};
        check(nEpUsed, 4'h0);
        check(nUdpMode, 1'b0);
        check(nUdpAdvert, udpCap);
        send(1'b1, PK_CTRL, AT_INIT_REQ, 8'h00, 6'h00, nMac);
        check(sentV, 1'b1);
        check(hdr.dscp, ctrlD);
        check(hdr.udpOn, 1'b1);
        check(hdr.vlanPcp, ctrlD[5:3]);
        check(gotV, 1'b1);
        check(nRxEp, 2'h0);
        check(nEpUsed, 4'h1);
        check(nRxHdr.vlanOn, 1'b0);
        check(nRxHdr.srcIp, cIp);
        check(nUdpMode, 1'b1);
        // each class upstream before and after its value is signalled
        for (i = 0; i < 4; i++) begin
            send(1'b0, upK[i], AT_NONE, 8'h02, 6'h11 + i[5:0], 48'h02CC_0000_0001);
            check(hdr.dscp, (i == 1 || i == 2) ? 6'h11 + i[5:0] : 6'h00);
            check(hdr.udpOn, 1'b1);
            check(hdr.srcIp, nIp);
            check(hdr.vlanId, 12'h00A);
            check(cRxHdr.vlanOn, 1'b0);
            check(cRxHdr.srcIp, nIp);
            check(gotV, 1'b1);
            send(1'b1, PK_CTRL, atK[i], 8'h02, 6'h00, nMac);
            check(hdr.attrDscp, aft[i]);
            send(1'b0, upK[i], AT_NONE, 8'h02, 6'h11 + i[5:0], 48'h02CC_0000_0001);
            check(hdr.dscp, aft[i]);
        end
        for (i = 0; i < 3; i++) begin
            send(1'b1, dnK[i], AT_NONE, 8'h05, 6'h00, nMac);
            check(hdr.dscp, dnE[i]);
            check(hdr.attr, AT_NONE);
            check(gotV, 1'b1);
        end
        send(1'b1, PK_CTRL, AT_NONE, 8'h00, 6'h00, nMac | 48'h0100_0000_0000);
        check({refd, sentV}, 2'b10);
        send(1'b0, PK_CTRL, AT_NONE, 8'h00, 6'h00, 48'h03CC_0000_0001);
        check({refd, sentV}, 2'b10);
        send(1'b1, PK_CTRL, AT_NONE, 8'h00, 6'h00, 48'h02AA_0000_0099);
        check(gotDrop, 1'b1);
        send(1'b0, PK_CTRL, AT_NONE, 8'h00, 6'h00, 48'h02CC_0000_0002);
        check({gotDrop, gotV}, 2'b10);
        // three further core addresses fit, a fifth does not
        for (i = 1; i < 5; i++) begin
            cIp = 128'h2001_0DB8_0000_0000_0000_0000_0B00_0001 + i;
            send(1'b1, PK_CTRL, AT_NONE, 8'h00, 6'h00, nMac);
            check(i < 4 ? {gotV, nRxEp} : {1'b0, gotDrop, 1'b0}, i < 4 ? {1'b1, i[1:0]} : 3'h2);
        end
        check(nEpUsed, 4'hF);
        cIp = 128'h2001_0DB8_0000_0000_0000_0000_0B00_0003;
        nTxEp = 2'h2;
        send(1'b0, PK_CTRL, AT_NONE, 8'h00, 6'h00, 48'h02CC_0000_0001);
        check(hdr.dstIp, cIp);
        check(gotV, 1'b1);
        ike = 1'b1;
        saRdy = 4'hB;
        send(1'b0, PK_DATA, AT_NONE, 8'h02, 6'h00, 48'h02CC_0000_0001);
        check({refd, sentV}, 2'b10);
        saRdy = 4'hF;
        send(1'b0, PK_DATA, AT_NONE, 8'h02, 6'h00, 48'h02CC_0000_0001);
        check({refd, sentV}, 2'b01);
        ike = 1'b0;
        v6 = 1'b1;
        send(1'b1, PK_CTRL, AT_NONE, 8'h00, 6'h00, nMac);
        check({hdr.ipV6, gotV}, 2'b11);
        send(1'b0, PK_CTRL, AT_NONE, 8'h00, 6'h00, 48'h02CC_0000_0001);
        check({hdr.ipV6, gotV}, 2'b11);
        udpCfg = 1'b0;
        vlan = 1'b0;
        send(1'b1, PK_CTRL, AT_INIT_REQ, 8'h00, 6'h00, nMac);
        check(hdr.udpOn, 1'b0);
        check(nUdpMode, 1'b1);
        check({hdr.vlanOn, hdr.vlanPcp, gotV}, 5'h01);
        udpCfg = 1'b1;
        nodeCap = 1'b0;
        send(1'b1, PK_CTRL, AT_NONE, 8'h00, 6'h00, nMac);
        check(hdr.udpOn, 1'b0);
        udpCap = 1'b0;
        #1;
        check(nUdpAdvert, 1'b0);
        complete_run(1'b0);
    end
endmodule
